// *** vrc_pkg.sv ***
// Purpose: Constants and types for the voltage reference control block.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
package vrc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] VRC_CTRL_OFS = 4'h0;
  localparam logic [3:0] VRC_STAT_OFS = 4'h4;
  localparam logic [7:0] VRC_CTRL_RST = 8'h00;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int VRC_POWER_BIT = 7;
  localparam int VRC_PIN_BIT = 6;
  localparam int VRC_RANGE_BIT = 5;
  localparam int VRC_SOURCE_BIT = 4;
  localparam int VRC_LEVEL_MSB = 3;
  localparam int VRC_LEVEL_W = 4;
  localparam int VRC_TAP_W = 32;
  // ----------------------------------------------------------------
  // Ladder geometry
  // ----------------------------------------------------------------
  localparam logic [5:0] VRC_HIGH_BASE = 6'h08;
  localparam logic [7:0] VRC_NO_TAP = 8'h00;
  localparam logic [31:0] VRC_TAP_OFF = 32'h0000_0000;
  typedef enum logic [1:0] {
    VRC_IDLE_S = 2'b01,
    VRC_ACK_S = 2'b10
  } vrc_bus_state_t;
endpackage

// *** vrc_tap_if.sv ***
// Purpose: Carries the ladder tap request from control to decoder.
// Assumes: Single clock domain.
// Notes: None.
`timescale 1ns/1ps
interface vrc_tap_if;
  logic power_on;
  logic range_sel;
  logic [3:0] level_code;
  logic [31:0] tap_sel;
  modport ctrl
  (
    output power_on,
    output range_sel,
    output level_code,
    input tap_sel
  );
  modport dec
  (
    input power_on,
    input range_sel,
    input level_code,
    output tap_sel
  );
endinterface

// *** vrc_tap_decode.sv ***
// Purpose: Registered one-hot ladder tap decoder.
// Assumes: Synchronous active-high reset.
// Notes: Low range uses taps 0..15 of a 32-step ladder scaled by 24.
`timescale 1ns/1ps
module vrc_tap_decode
(
  input wire logic clk_i,
  input wire logic reset_i,
  vrc_tap_if.dec tap
);
  import vrc_pkg::*;
  logic [31:0] tap_reg;
  logic [5:0] index;
  always_comb
  begin
    index = tap.range_sel ? {2'b00, tap.level_code} : VRC_HIGH_BASE + {2'b00, tap.level_code};
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      tap_reg <= VRC_TAP_OFF;
    else if (!tap.power_on)
      tap_reg <= VRC_TAP_OFF;
    else
      tap_reg <= 32'h1 << index[4:0];
  end
  assign tap.tap_sel = tap_reg;

  property p_tap_off;
    @(posedge clk_i) disable iff (reset_i) !tap.power_on |=> tap_reg == VRC_TAP_OFF;
  endproperty
  a_tap_off: assert property (p_tap_off) else $error("Tap active while off.");
  property p_tap_onehot;
    @(posedge clk_i) disable iff (reset_i) tap.power_on |=> $onehot(tap_reg);
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("Tap not one-hot.");
  property p_range_low;
    @(posedge clk_i) disable iff (reset_i)
      tap.power_on && tap.range_sel |=> tap_reg[15:0] != 16'h0;
  endproperty
  a_range_low: assert property (p_range_low) else $error("Low range tap wrong.");
  property p_range_high;
    @(posedge clk_i) disable iff (reset_i)
      tap.power_on && !tap.range_sel |=> tap_reg[7:0] == 8'h00 && tap_reg[31:24] == 8'h00;
  endproperty
  a_range_high: assert property (p_range_high) else $error("High range tap wrong.");
  c_low: cover property (@(posedge clk_i) tap.power_on && tap.range_sel);
  c_high: cover property (@(posedge clk_i) tap.power_on && !tap.range_sel);
endmodule

// *** vrc_top.sv ***
// Purpose: Voltage reference control register and ladder control outputs.
// Assumes: Avalon-MM slave, 32-bit data, one 40 MHz clock.
// Notes: Sleep wake-up is not a reset and leaves the register alone.
// Operation
// - Power bit powers ladder on or off.
// - Pin drive bit routes reference to pin.
// - Pin drive overrides pin direction bit.
// - Bit five selects low or high range.
// - Bit four selects reference or supply source.
// - Level code picks one of sixteen taps.
// - Reset clears the control register.
// - Sleep wake-up leaves register unchanged.
// - Runs independent of comparator state.
`timescale 1ns/1ps
module vrc_top
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic [1:0] AVS_RESPONSE_O,
  input wire logic PORT_A2_DIR_I,
  input wire logic PORT_A2_OUT_I,
  input wire logic WAKE_I,
  output logic LADDER_POWER_DOWN_O,
  output logic SOURCE_EXT_O,
  output logic [vrc_pkg::VRC_TAP_W-1:0] TAP_SEL_O,
  output logic PIN_A2_REF_CONNECT_O,
  output logic PIN_A2_OUT_O,
  output logic PIN_A2_OE_N_O
);
  import vrc_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  vrc_bus_state_t state_reg;
  logic [7:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic [7:0] status_val;
  vrc_tap_if tap_bus();

  assign req = AVS_READ_I || AVS_WRITE_I;
  assign hit_ctrl = AVS_ADDRESS_I == VRC_CTRL_OFS;
  assign hit_stat = AVS_ADDRESS_I == VRC_STAT_OFS;
  // One wait cycle; the request is acknowledged on the second edge.
  assign AVS_WAITREQUEST_O = !(state_reg == VRC_ACK_S);
  assign AVS_READDATA_O = rdata_reg;
  assign AVS_RESPONSE_O = resp_reg;

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      state_reg <= VRC_IDLE_S;
    else
    begin
      unique case (state_reg)
        VRC_IDLE_S: if (req) state_reg <= VRC_ACK_S;
        VRC_ACK_S: state_reg <= VRC_IDLE_S;
        default: state_reg <= VRC_IDLE_S;
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      ctrl_reg <= VRC_CTRL_RST;
    // wake-up untouched
    // The write lands at the acknowledge edge, where the master is known to hold it.
    else if (AVS_WRITE_I && state_reg == VRC_ACK_S && hit_ctrl && AVS_BYTEENABLE_I[0])
      ctrl_reg <= AVS_WRITEDATA_I[7:0];
  end

  assign status_val = {7'h00, |TAP_SEL_O};

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'h0;
    end
    else if (req && state_reg == VRC_IDLE_S)
    begin
      resp_reg <= (hit_ctrl || hit_stat) ? 2'h0 : 2'h3;
      if (AVS_READ_I && hit_ctrl)
        rdata_reg <= {24'h000000, ctrl_reg};
      else if (AVS_READ_I && hit_stat)
        rdata_reg <= {24'h000000, status_val};
      else
        rdata_reg <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Ladder and pin control
  // ----------------------------------------------------------------
  // no comparator inputs
  assign tap_bus.power_on = ctrl_reg[VRC_POWER_BIT];
  assign tap_bus.range_sel = ctrl_reg[VRC_RANGE_BIT];
  assign tap_bus.level_code = ctrl_reg[VRC_LEVEL_MSB -: VRC_LEVEL_W];

  vrc_tap_decode u_dec
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .tap(tap_bus)
  );
  assign TAP_SEL_O = tap_bus.tap_sel;

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      LADDER_POWER_DOWN_O <= 1'b1;
      SOURCE_EXT_O <= 1'b0;
      PIN_A2_REF_CONNECT_O <= 1'b0;
      PIN_A2_OUT_O <= 1'b0;
      PIN_A2_OE_N_O <= 1'b1;
    end
    else
    begin
      LADDER_POWER_DOWN_O <= !ctrl_reg[VRC_POWER_BIT];
      SOURCE_EXT_O <= ctrl_reg[VRC_SOURCE_BIT];
      PIN_A2_REF_CONNECT_O <= ctrl_reg[VRC_PIN_BIT];
      PIN_A2_OUT_O <= PORT_A2_OUT_I;
      PIN_A2_OE_N_O <= ctrl_reg[VRC_PIN_BIT] ? 1'b1 : PORT_A2_DIR_I;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_power;
    @(posedge CLK_I) disable iff (RESET_I)
      1'b1 |=> LADDER_POWER_DOWN_O == !$past(ctrl_reg[VRC_POWER_BIT]);
  endproperty
  a_power: assert property (p_power) else $error("Power state wrong.");
  property p_pin;
    @(posedge CLK_I) disable iff (RESET_I)
      ctrl_reg[VRC_PIN_BIT] |=> PIN_A2_REF_CONNECT_O;
  endproperty
  a_pin: assert property (p_pin) else $error("Pin not connected.");
  property p_override;
    @(posedge CLK_I) disable iff (RESET_I)
      ctrl_reg[VRC_PIN_BIT] && !PORT_A2_DIR_I |=> PIN_A2_OE_N_O;
  endproperty
  a_override: assert property (p_override) else $error("Direction not overridden.");
  property p_source;
    @(posedge CLK_I) disable iff (RESET_I)
      1'b1 |=> SOURCE_EXT_O == $past(ctrl_reg[VRC_SOURCE_BIT]);
  endproperty
  a_source: assert property (p_source) else $error("Source wrong.");
  property p_reset;
    @(posedge CLK_I) RESET_I |=> ctrl_reg == VRC_CTRL_RST;
  endproperty
  a_reset: assert property (p_reset) else $error("Reset did not clear.");
  property p_hold;
    @(posedge CLK_I) disable iff (RESET_I)
      !AVS_WRITE_I ##1 WAKE_I |-> $stable(ctrl_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("Register changed on wake.");
  property p_ack;
    @(posedge CLK_I) disable iff (RESET_I)
      req && state_reg == VRC_IDLE_S |=> !AVS_WAITREQUEST_O;
  endproperty
  a_ack: assert property (p_ack) else $error("No acknowledge.");

  // ----------------------------------------------------------------
  // Pin, ladder tap and register checks
  // ----------------------------------------------------------------
  property p_pin_off;
    @(posedge CLK_I) disable iff (RESET_I)
      !ctrl_reg[VRC_PIN_BIT] |=> !PIN_A2_REF_CONNECT_O;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Pin still connected.");
  property p_dir_follow;
    @(posedge CLK_I) disable iff (RESET_I)
      !ctrl_reg[VRC_PIN_BIT] |=> PIN_A2_OE_N_O == $past(PORT_A2_DIR_I);
  endproperty
  a_dir_follow: assert property (p_dir_follow) else $error("Direction ignored.");
  property p_pin_out;
    @(posedge CLK_I) disable iff (RESET_I)
      1'b1 |=> PIN_A2_OUT_O == $past(PORT_A2_OUT_I);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("Port data wrong.");
  property p_tap_dark;
    @(posedge CLK_I) disable iff (RESET_I)
      LADDER_POWER_DOWN_O |-> TAP_SEL_O == VRC_TAP_OFF;
  endproperty
  a_tap_dark: assert property (p_tap_dark) else $error("Tap active in power down.");
  property p_no_stray;
    @(posedge CLK_I) disable iff (RESET_I)
      !(AVS_WRITE_I && !AVS_WAITREQUEST_O) |=> $stable(ctrl_reg);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("Register changed unwritten.");
  property p_reset_out;
    @(posedge CLK_I)
      RESET_I |=> LADDER_POWER_DOWN_O && !PIN_A2_REF_CONNECT_O && PIN_A2_OE_N_O;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("Outputs not reset.");
  c_write: cover property (@(posedge CLK_I) AVS_WRITE_I && !AVS_WAITREQUEST_O && hit_ctrl);
  c_pin: cover property (@(posedge CLK_I) PIN_A2_REF_CONNECT_O);
  c_on: cover property (@(posedge CLK_I) !LADDER_POWER_DOWN_O);
endmodule

// *** test_voltage_reference_control.sv ***
// Purpose: Self-checking bench for the voltage reference control block.
// Assumes: 40 MHz clock, synchronous active-high reset, Avalon-MM master.
// Notes: Expected values are noted in queues and checked by watcher processes.
`timescale 1ns/1ps
module test_voltage_reference_control;
  import vrc_pkg::*;
  logic clk, rst, rd, wr, dir, pout, wake, wreq, pd, src, conn, pin_o, oe_n;
  logic [3:0] adr, be;
  logic [31:0] wdat, rdat;
  logic [1:0] resp;
  logic [VRC_TAP_W-1:0] tap;
  logic [7:0] ctrl;
  logic [33:0] rd_q[$];
  logic [36:0] out_q[$];
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  event out_ev;
  vrc_top vrc_top_i (.CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .AVS_RESPONSE_O(resp), .PORT_A2_DIR_I(dir),
    .PORT_A2_OUT_I(pout), .WAKE_I(wake), .LADDER_POWER_DOWN_O(pd), .SOURCE_EXT_O(src),
    .TAP_SEL_O(tap), .PIN_A2_REF_CONNECT_O(conn), .PIN_A2_OUT_O(pin_o), .PIN_A2_OE_N_O(oe_n));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task close_out;
    failures += rd_q.size() + out_q.size();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_out(input logic [36:0] got, input logic [36:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t outputs got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data is taken at the rising edge at which waitrequest is seen low.
  always @(posedge clk)
    if (rd === 1'b1 && wreq === 1'b0 && rd_q.size() > 0)
      cmp_rd({resp, rdat}, rd_q.pop_front());
  always @(out_ev)
    cmp_out({pd, src, tap, conn, pin_o, oe_n}, out_q.pop_front());
  // Twenty thousand cycles is far beyond the roughly 730 the tests need.
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc > 20000)
    begin
      failures++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [36:0] exp_out(logic [7:0] c, logic d, logic o);
    logic [31:0] t;
    t = '0;
    if (c[VRC_POWER_BIT])
      t[c[VRC_RANGE_BIT] ? {1'b0, c[3:0]} : {1'b0, c[3:0]} + 5'd8] = 1'b1;
    return {~c[VRC_POWER_BIT], c[VRC_SOURCE_BIT], t, c[VRC_PIN_BIT], o, c[VRC_PIN_BIT] | d};
  endfunction
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    rd_q.push_back({r, d});
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  task out_chk(input logic [7:0] c);
    repeat (4) @(posedge clk);
    out_q.push_back(exp_out(c, dir, pout));
    @(negedge clk);
    ->out_ev;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0; be = 4'h0;
    dir = 1'b1; pout = 1'b0; wake = 1'b0; rst = 1'b1;
    void'($urandom(32'h1ae8));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    out_chk(8'h00);
    rd_chk(VRC_CTRL_OFS, 32'h0, 2'b00);
    for (int k = 0; k < 48; k++)
    begin
      ctrl = (k < 32) ? {1'b1, k[0] ^ k[2], k[4], k[1], k[3:0]} : 8'($urandom);
      @(posedge clk);
      dir <= 1'($urandom);
      pout <= 1'($urandom);
      bus(1'b1, VRC_CTRL_OFS, {24'h0, ctrl}, 4'h1);
      out_chk(ctrl);
      rd_chk(VRC_CTRL_OFS, {24'h0, ctrl}, 2'b00);
      rd_chk(VRC_STAT_OFS, {31'h0, ctrl[7]}, 2'b00);
    end
    ctrl = 8'h55; // power off before sleep
    bus(1'b1, VRC_CTRL_OFS, {24'h0, ctrl}, 4'h1);
    @(posedge clk);
    wake <= 1'b1;
    repeat (3) @(posedge clk);
    wake <= 1'b0;
    out_chk(ctrl);
    rd_chk(VRC_CTRL_OFS, {24'h0, ctrl}, 2'b00);
    bus(1'b1, 4'h8, 32'h0000_00ff, 4'h1);
    bus(1'b1, VRC_CTRL_OFS, 32'h0000_00ff, 4'h0);
    rd_chk(4'h8, 32'h0, 2'b11);
    rd_chk(VRC_CTRL_OFS, {24'h0, ctrl}, 2'b00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    out_chk(8'h00);
    rd_chk(VRC_CTRL_OFS, 32'h0, 2'b00);
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule
